// ---- design/cat_regs.svh ----
// register offsets, field positions, reset values and divider counts of the counter array
// assumes byte addresses on a 32-bit bus, one aligned word per register
`ifndef CAT_REGS_SVH
`define CAT_REGS_SVH

`define CAT_OFF_MODE 8'h00
`define CAT_OFF_CONTROL 8'h04
`define CAT_OFF_COUNT_LO 8'h08
`define CAT_OFF_COUNT_HI 8'h0C
`define CAT_OFF_IRQ_STATUS 8'h10
`define CAT_OFF_IRQ_MASK 8'h14
`define CAT_OFF_CONFIG 8'h18
`define CAT_OFF_MOD_BASE 8'h20
`define CAT_OFF_MOD_STRIDE 8'h10
`define CAT_OFF_MOD_MODE 8'h00
`define CAT_OFF_MOD_LO 8'h04
`define CAT_OFF_MOD_HI 8'h08

`define CAT_BIT_OVF_FLAG 7
`define CAT_BIT_RUN 6
`define CAT_BIT_DOUBLE_SPEED 0
`define CAT_IRQ_BIT_OVF 0
`define CAT_IRQ_MOD_LSB 1

`define CAT_RST_MODE 8'h00
`define CAT_RST_CONTROL 8'h00
`define CAT_RST_COUNT 16'h0000
`define CAT_RST_IRQ 6'h00
`define CAT_RST_MOD_MODE 8'h00
`define CAT_RST_MOD_VALUE 16'h0000

`define CAT_DIV_SLOW_STD 4'hC
`define CAT_DIV_SLOW_DBL 4'h6
`define CAT_DIV_FAST_STD 4'h4
`define CAT_DIV_FAST_DBL 4'h2

`endif

// ---- design/cat_pkg.sv ----
// types shared by the counter array time base and its capture/compare modules
// assumes cat_regs.svh holds every number
package cat_pkg;

	typedef enum logic [1:0] {
		CAT_SRC_SLOW,
		CAT_SRC_FAST,
		CAT_SRC_T0,
		CAT_SRC_EXT
	} cat_source_type;

	typedef struct packed {
		logic reserved_7;
		logic wdt_enable;
		logic [2:0] reserved_5_3;
		cat_source_type source_select;
		logic overflow_irq_enable;
	} cat_mode_type;

	typedef struct packed {
		logic counter_overflow_flag;
		logic counter_run;
		logic reserved_5;
		logic [4:0] module_event_flag;
	} cat_control_type;

	typedef struct packed {
		logic reserved_7;
		logic compare_enable;
		logic capture_rise;
		logic capture_fall;
		logic match_enable;
		logic toggle_enable;
		logic pwm_enable;
		logic module_event_irq_enable;
	} cat_module_mode_type;

	typedef struct packed {
		logic [31:0] addr;
		logic write;
	} cat_bus_req_type;

endpackage : cat_pkg

// ---- design/cat_module_unit.sv ----
// one capture/compare module referenced to the shared 16-bit count
// assumes pin level synchronous to hclk and write strobes from the bus slave
`timescale 1ns/100ps
`include "cat_regs.svh"

module cat_module_unit import cat_pkg::*; (
	input wire logic hclk,
	input wire logic hresetn,
	input wire logic [15:0] count,
	input wire logic count_moved,
	input wire logic pin_level,
	input wire logic write_mode,
	input wire logic write_low,
	input wire logic write_high,
	input wire logic [7:0] write_data,
	output cat_module_mode_type mode,
	output logic [15:0] capture_value,
	output logic pin_drive,
	output logic pin_use,
	output logic event_pulse,
	output logic match_pulse
);

	logic pin_prev;
	logic capture_hit;
	logic match_hit;

	////////////////////////////////////////////////////////////////////////////////////////////
	assign capture_hit = (pin_level & ~pin_prev & mode.capture_rise) |
		(~pin_level & pin_prev & mode.capture_fall);
	// compare only on a fresh count value, so a stopped counter does not repeat the match
	assign match_hit = mode.compare_enable & ~mode.pwm_enable & count_moved &
		(count == capture_value);
	assign pin_use = mode.toggle_enable | mode.pwm_enable;

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			mode <= cat_module_mode_type'(`CAT_RST_MOD_MODE);
		end else if (write_mode) begin
			mode <= cat_module_mode_type'(write_data);
		end
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			capture_value <= `CAT_RST_MOD_VALUE;
		end else if (write_low) begin
			capture_value[7:0] <= write_data;
		end else if (write_high) begin
			capture_value[15:8] <= write_data;
		end else if (capture_hit) begin
			capture_value <= count;
		end else if (mode.pwm_enable && count_moved && count[7:0] == 8'h00) begin
			// duty reload only at the low byte wrap so a cycle never glitches
			capture_value[7:0] <= capture_value[15:8];
		end
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			pin_prev <= 1'h0;
			pin_drive <= 1'h0;
			event_pulse <= 1'h0;
			match_pulse <= 1'h0;
		end else begin
			pin_prev <= pin_level;
			event_pulse <= capture_hit | (match_hit & mode.match_enable);
			match_pulse <= match_hit & mode.match_enable;
			if (mode.pwm_enable) begin
				pin_drive <= (count[7:0] >= capture_value[7:0]);
			end else if (match_hit && mode.toggle_enable) begin
				pin_drive <= ~pin_drive;
			end
		end
	end

endmodule : cat_module_unit

// ---- design/cat_time_base.sv ----
// counter array time base: AHB-Lite slave, prescaler, 16-bit count, flags, five modules
// assumes hclk is the oscillator, port pins and timer0 pulse synchronous to hclk
//
// Notes on behaviour
// - one shared free-running 16-bit count
// - two-bit select picks count increment source
// - mode bits 2:1 source, bit 0 irq enable
// - timer0 overflow counts regardless of its irq
// - count advances only while run bit set
// - overflow sets flag, irq if enabled
// - only software clears overflow flag
// - each module owns sticky event flag
// - modules on port bits 3..7, input bit 2
// - capture, timer, fast output and pwm modes
// - module 4 adds watchdog reset
// - unused module pins stay ordinary port
// - per-module enable lets flag raise irq
`timescale 1ns/100ps
`include "cat_regs.svh"

module cat_time_base import cat_pkg::*; (
	input wire logic hclk,
	input wire logic hresetn,
	input wire logic hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [2:0] hsize,
	input wire logic [31:0] hwdata,
	input wire logic hready,
	output logic hreadyout,
	output logic hresp,
	output logic [31:0] hrdata,
	input wire logic timer0_overflow,
	input wire logic [7:0] port1_in,
	input wire logic [7:0] port1_latch,
	input wire logic [7:0] port1_latch_oe_n,
	output logic [7:0] port1_out,
	output logic [7:0] port1_oe_n,
	output logic wdt_reset,
	output logic irq
);

	cat_bus_req_type req;
	logic req_write;
	logic rd_wait;
	logic wr_en;
	logic [7:0] wr_off;
	logic [7:0] rd_off;
	logic off_ok;
	logic [31:0] next_rdata;
	cat_mode_type mode;
	cat_control_type control;
	logic double_speed;
	logic [15:0] count;
	logic [3:0] presc_slow;
	logic [3:0] presc_fast;
	logic [3:0] div_slow;
	logic [3:0] div_fast;
	logic tick_slow;
	logic tick_fast;
	logic ext_sync1;
	logic ext_sync2;
	logic ext_prev;
	logic ext_fall;
	logic inc_sel;
	logic advance;
	logic count_write;
	logic count_moved;
	logic overflow_event;
	logic [5:0] irq_status;
	logic [5:0] irq_mask;
	logic [5:0] irq_set;
	cat_module_mode_type mod_mode [5];
	logic [15:0] mod_value [5];
	logic [4:0] mod_drive;
	logic [4:0] mod_use;
	logic [4:0] mod_event;
	logic [4:0] mod_match;
	logic [4:0] mod_irq_en;

	////////////////////////////////////////////////////////////////////////////////////////////
	// bus slave: writes land with zero wait, reads take one wait state so that a read
	// right after a write always sees the written value
	assign hresp = 1'h0;
	assign hreadyout = ~rd_wait;
	assign wr_off = req.addr[7:0];
	assign rd_off = req.addr[7:0];
	assign off_ok = (req.addr[31:8] == 24'h000000);
	assign wr_en = req_write & off_ok;

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			req <= '0;
			req_write <= 1'h0;
			rd_wait <= 1'h0;
		end else begin
			req_write <= 1'h0;
			if (rd_wait) begin
				rd_wait <= 1'h0;
			end else if (hsel && htrans[1] && hready) begin
				req <= '{addr: haddr, write: hwrite};
				req_write <= hwrite;
				rd_wait <= ~hwrite;
			end
		end
	end

	always_comb begin
		next_rdata = 32'h00000000;
		if (off_ok) begin
			case (rd_off)
				`CAT_OFF_MODE: next_rdata[7:0] = mode;
				`CAT_OFF_CONTROL: next_rdata[7:0] = control;
				`CAT_OFF_COUNT_LO: next_rdata[7:0] = count[7:0];
				`CAT_OFF_COUNT_HI: next_rdata[7:0] = count[15:8];
				`CAT_OFF_IRQ_STATUS: next_rdata[5:0] = irq_status;
				`CAT_OFF_IRQ_MASK: next_rdata[5:0] = irq_mask;
				`CAT_OFF_CONFIG: next_rdata[`CAT_BIT_DOUBLE_SPEED] = double_speed;
				default: next_rdata = 32'h00000000;
			endcase
			for (int k = 0; k < 5; k++) begin
				if (rd_off == 8'(`CAT_OFF_MOD_BASE + k * `CAT_OFF_MOD_STRIDE + `CAT_OFF_MOD_MODE)) begin
					next_rdata[7:0] = mod_mode[k];
				end
				if (rd_off == 8'(`CAT_OFF_MOD_BASE + k * `CAT_OFF_MOD_STRIDE + `CAT_OFF_MOD_LO)) begin
					next_rdata[7:0] = mod_value[k][7:0];
				end
				if (rd_off == 8'(`CAT_OFF_MOD_BASE + k * `CAT_OFF_MOD_STRIDE + `CAT_OFF_MOD_HI)) begin
					next_rdata[7:0] = mod_value[k][15:8];
				end
			end
		end
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			hrdata <= 32'h00000000;
		end else if (rd_wait) begin
			hrdata <= next_rdata;
		end
	end

	////////////////////////////////////////////////////////////////////////////////////////////
	// configuration registers
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			mode <= cat_mode_type'(`CAT_RST_MODE);
			double_speed <= 1'h0;
		end else if (wr_en && wr_off == `CAT_OFF_MODE) begin
			mode <= cat_mode_type'(hwdata[7:0]);
		end else if (wr_en && wr_off == `CAT_OFF_CONFIG) begin
			double_speed <= hwdata[`CAT_BIT_DOUBLE_SPEED];
		end
	end

	////////////////////////////////////////////////////////////////////////////////////////////
	// prescaler: one-cycle enables; a >= compare keeps a speed change mid-count from missing the end value
	assign div_slow = double_speed ? `CAT_DIV_SLOW_DBL : `CAT_DIV_SLOW_STD;
	assign div_fast = double_speed ? `CAT_DIV_FAST_DBL : `CAT_DIV_FAST_STD;
	assign tick_slow = (presc_slow >= div_slow - 4'h1);
	assign tick_fast = (presc_fast >= div_fast - 4'h1);

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			presc_slow <= 4'h0;
			presc_fast <= 4'h0;
		end else begin
			presc_slow <= tick_slow ? 4'h0 : presc_slow + 4'h1;
			presc_fast <= tick_fast ? 4'h0 : presc_fast + 4'h1;
		end
	end

	// external count input: two-stage synchroniser, edge taken after the second stage;
	// the edge detector can only resolve a rate well below the oscillator
	assign ext_fall = ext_prev & ~ext_sync2;
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			ext_sync1 <= 1'h1;
			ext_sync2 <= 1'h1;
			ext_prev <= 1'h1;
		end else begin
			ext_sync1 <= port1_in[2];
			ext_sync2 <= ext_sync1;
			ext_prev <= ext_sync2;
		end
	end

	always_comb begin
		case (mode.source_select)
			CAT_SRC_SLOW: inc_sel = tick_slow;
			CAT_SRC_FAST: inc_sel = tick_fast;
			CAT_SRC_T0: inc_sel = timer0_overflow;
			CAT_SRC_EXT: inc_sel = ext_fall;
			default: inc_sel = 1'h0;
		endcase
	end

	////////////////////////////////////////////////////////////////////////////////////////////
	// shared time base
	assign advance = control.counter_run & inc_sel;
	assign count_write = wr_en & (wr_off == `CAT_OFF_COUNT_LO || wr_off == `CAT_OFF_COUNT_HI);
	assign overflow_event = advance & ~count_write & (count == 16'hFFFF);

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			count <= `CAT_RST_COUNT;
			count_moved <= 1'h0;
		end else begin
			count_moved <= advance & ~count_write;
			if (wr_en && wr_off == `CAT_OFF_COUNT_LO) begin
				count[7:0] <= hwdata[7:0];
			end else if (wr_en && wr_off == `CAT_OFF_COUNT_HI) begin
				count[15:8] <= hwdata[7:0];
			end else if (advance) begin
				count <= count + 16'h0001;
			end
		end
	end

	// flags: a write of zero clears, a write of one leaves alone; a same-cycle event wins
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			control <= cat_control_type'(`CAT_RST_CONTROL);
		end else begin
			if (wr_en && wr_off == `CAT_OFF_CONTROL) begin
				control.counter_run <= hwdata[`CAT_BIT_RUN];
				control.counter_overflow_flag <= (control.counter_overflow_flag &
					hwdata[`CAT_BIT_OVF_FLAG]) | overflow_event;
				control.module_event_flag <= (control.module_event_flag & hwdata[4:0]) |
					mod_event;
			end else begin
				control.counter_overflow_flag <= control.counter_overflow_flag |
					overflow_event;
				control.module_event_flag <= control.module_event_flag | mod_event;
			end
		end
	end

	////////////////////////////////////////////////////////////////////////////////////////////
	// interrupt status: events qualified by their enables, write one to clear, set wins
	assign irq_set = {mod_event & mod_irq_en, overflow_event & mode.overflow_irq_enable};

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			irq_status <= `CAT_RST_IRQ;
			irq_mask <= `CAT_RST_IRQ;
		end else begin
			if (wr_en && wr_off == `CAT_OFF_IRQ_STATUS) begin
				irq_status <= (irq_status & ~hwdata[5:0]) | irq_set;
			end else begin
				irq_status <= irq_status | irq_set;
			end
			if (wr_en && wr_off == `CAT_OFF_IRQ_MASK) begin
				irq_mask <= hwdata[5:0];
			end
		end
	end

	assign irq = |(irq_status & irq_mask);

	////////////////////////////////////////////////////////////////////////////////////////////
	// capture/compare modules on port bits 3..7
	for (genvar i = 0; i < 5; i++) begin : g_mod
		cat_module_unit u_unit (
			.hclk(hclk),
			.hresetn(hresetn),
			.count(count),
			.count_moved(count_moved),
			.pin_level(port1_in[i + 3]),
			.write_mode(wr_en && wr_off ==
				8'(`CAT_OFF_MOD_BASE + i * `CAT_OFF_MOD_STRIDE + `CAT_OFF_MOD_MODE)),
			.write_low(wr_en && wr_off ==
				8'(`CAT_OFF_MOD_BASE + i * `CAT_OFF_MOD_STRIDE + `CAT_OFF_MOD_LO)),
			.write_high(wr_en && wr_off ==
				8'(`CAT_OFF_MOD_BASE + i * `CAT_OFF_MOD_STRIDE + `CAT_OFF_MOD_HI)),
			.write_data(hwdata[7:0]),
			.mode(mod_mode[i]),
			.capture_value(mod_value[i]),
			.pin_drive(mod_drive[i]),
			.pin_use(mod_use[i]),
			.event_pulse(mod_event[i]),
			.match_pulse(mod_match[i])
		);
		assign mod_irq_en[i] = mod_mode[i].module_event_irq_enable;
		assign port1_out[i + 3] = mod_use[i] ? mod_drive[i] : port1_latch[i + 3];
		assign port1_oe_n[i + 3] = mod_use[i] ? 1'h0 : port1_latch_oe_n[i + 3];
	end

	assign port1_out[2:0] = port1_latch[2:0];
	assign port1_oe_n[2:0] = port1_latch_oe_n[2:0];

	// only module 4 may reset the chip, and only with the watchdog enable set
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			wdt_reset <= 1'h0;
		end else begin
			wdt_reset <= mode.wdt_enable & mod_match[4];
		end
	end

	////////////////////////////////////////////////////////////////////////////////////////////
	a_ovf_sets_flag: assert property (@(posedge hclk) disable iff (!hresetn)
		overflow_event |=> control.counter_overflow_flag && count == 16'h0000)
		else $error("overflow did not set the flag");

	a_ovf_flag_sticky: assert property (@(posedge hclk) disable iff (!hresetn)
		control.counter_overflow_flag && !(wr_en && wr_off == `CAT_OFF_CONTROL)
		|=> control.counter_overflow_flag)
		else $error("overflow flag cleared by hardware");

	a_stop_holds: assert property (@(posedge hclk) disable iff (!hresetn)
		!control.counter_run && !count_write |=> $stable(count))
		else $error("count moved while stopped");

	a_fast_divide: assert property (@(posedge hclk) disable iff (!hresetn)
		tick_fast && !double_speed && $stable(double_speed)
		|=> (!tick_fast || double_speed) [*3] ##1 (tick_fast || double_speed))
		else $error("fast rate is not one in four");

	// a speed change inside the window excuses the rate, the divider keeps its count and ticks once at or past the new end value
	a_slow_divide: assert property (@(posedge hclk) disable iff (!hresetn)
		tick_slow && double_speed && $stable(double_speed)
		|=> (!tick_slow || !double_speed) [*5] ##1 (tick_slow || !double_speed))
		else $error("double speed slow rate is not one in six");

	a_t0_counts: assert property (@(posedge hclk) disable iff (!hresetn)
		control.counter_run && mode.source_select == CAT_SRC_T0 && timer0_overflow &&
		!count_write |=> count == $past(count) + 16'h0001)
		else $error("timer0 overflow not counted");

	a_ext_edge: assert property (@(posedge hclk) disable iff (!hresetn)
		$past(port1_in[2]) && !port1_in[2] ##2 control.counter_run &&
		mode.source_select == CAT_SRC_EXT && !count_write
		|=> count == $past(count) + 16'h0001)
		else $error("external falling edge not counted");

	a_mod_flag: assert property (@(posedge hclk) disable iff (!hresetn)
		mod_event[0] |=> control.module_event_flag[0])
		else $error("module event flag not set");

	a_count_load: assert property (@(posedge hclk) disable iff (!hresetn)
		wr_en && wr_off == `CAT_OFF_COUNT_LO |=> count[7:0] == $past(hwdata[7:0]))
		else $error("count low byte not loaded");

	a_read_wait: assert property (@(posedge hclk) disable iff (!hresetn)
		hsel && htrans[1] && hready && !hwrite && hreadyout |=> !hreadyout ##1 hreadyout)
		else $error("read wait state wrong");

	a_wdt_source: assert property (@(posedge hclk) disable iff (!hresetn)
		wdt_reset |-> $past(mode.wdt_enable) && $past(mod_match[4]))
		else $error("watchdog reset without module 4 match");

	c_overflow: cover property (@(posedge hclk) disable iff (!hresetn) overflow_event);
	c_capture: cover property (@(posedge hclk) disable iff (!hresetn) mod_event[1] && !mod_match[1]);
	c_watchdog: cover property (@(posedge hclk) disable iff (!hresetn) wdt_reset);
	c_irq: cover property (@(posedge hclk) disable iff (!hresetn) irq);

endmodule : cat_time_base

// ---- test/cat_far_model.sv ----
// far side of the counter array: external count input, module event pins, timer0 pulses
// assumes tasks are called right after a rising edge of hclk
`timescale 1ns/100ps

module cat_far_model (
	input wire logic hclk,
	output logic [7:0] port1_in,
	output logic timer0_overflow
);
	logic ext_level;
	logic [4:0] pins;
	logic [1:0] spare;

	////////////////////////////////////////////////////////////////////////////////
	initial begin
		ext_level = 1'b1;
		pins = 5'h00;
		spare = 2'h1;
		timer0_overflow = 1'b0;
	end

	// unused bits keep moving so no settled value is mistaken for a driven one
	always @(posedge hclk) begin
		spare <= ~spare;
	end

	assign port1_in = {pins, ext_level, spare};

	////////////////////////////////////////////////////////////////////////////////
	task pulse_t0(input int n);
		repeat (n) begin
			timer0_overflow <= 1'b1;
			@(posedge hclk);
			timer0_overflow <= 1'b0;
			repeat (4) @(posedge hclk);
		end
	endtask : pulse_t0

	// half period of four clocks keeps the input at osc/8 at most
	task ext_falls(input int n);
		repeat (n) begin
			ext_level <= 1'b0;
			repeat (4) @(posedge hclk);
			ext_level <= 1'b1;
			repeat (4) @(posedge hclk);
		end
	endtask : ext_falls

	task set_pin(input int m, input logic v);
		pins[m] <= v;
		@(posedge hclk);
	endtask : set_pin
endmodule : cat_far_model

// ---- test/cat_time_base_tb.sv ----
// self-checking bench of the counter array time base over an AHB-Lite master
// assumes one slave on the bus, so hready is the slave's hreadyout
`timescale 1ns/100ps
`include "cat_regs.svh"

module cat_time_base_tb;
	logic hclk, hresetn, hsel, hwrite, hreadyout, hresp, timer0_overflow, wdt_reset, irq;
	logic [31:0] haddr, hwdata, hrdata, q;
	logic [1:0] htrans;
	logic [7:0] port1_in, port1_latch, port1_latch_oe_n, port1_out, port1_oe_n;
	int err_count, n_checks, cyc, lat, a, v, n, m, wdt_hits;
	int divs[4] = '{12, 6, 4, 2};

	cat_time_base u_dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
		.htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout),
		.hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .timer0_overflow(timer0_overflow),
		.port1_in(port1_in), .port1_latch(port1_latch), .port1_latch_oe_n(port1_latch_oe_n),
		.port1_out(port1_out), .port1_oe_n(port1_oe_n), .wdt_reset(wdt_reset), .irq(irq));
	cat_far_model u_far (.hclk(hclk), .port1_in(port1_in), .timer0_overflow(timer0_overflow));

	////////////////////////////////////////////////////////////////////////////////
	initial begin
		hclk = 1'b0;
		forever #50 hclk = ~hclk;
	end

	always @(posedge hclk) cyc <= cyc + 1;

	// reset pulses are counted so a missing or doubled pulse is seen
	always @(posedge hclk) begin
		if (wdt_reset === 1'b1) begin
			wdt_hits <= wdt_hits + 1;
		end
	end

	// one single transfer; waits on hready with no assumed latency
	task bus(input logic [31:0] ad, input logic w, input logic [31:0] d);
		int st;
		st = cyc;
		hsel <= 1'b1;
		htrans <= 2'h2;
		haddr <= ad;
		hwrite <= w;
		do @(posedge hclk); while (hreadyout !== 1'b1);
		htrans <= 2'h0;
		hsel <= 1'b0;
		hwdata <= d;
		do @(posedge hclk); while (hreadyout !== 1'b1);
		q = hrdata;
		lat = cyc - st;
	endtask : bus

	task wr(input logic [31:0] ad, input logic [31:0] d);
		bus(ad, 1'b1, d);
	endtask : wr

	task chk(input logic [31:0] got, input logic [31:0] exp);
		n_checks++;
		if (got !== exp) begin
			err_count++;
			$display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : chk

	task rchk(input logic [31:0] ad, input logic [31:0] exp);
		bus(ad, 1'b0, 32'h0);
		chk(q, exp);
	endtask : rchk

	// pins are sampled one edge later so the last register update has landed
	task pchk(input logic [7:0] got_sel, input logic [7:0] mask, input logic [7:0] exp);
		@(posedge hclk);
		chk({24'h0, (got_sel ? port1_oe_n : port1_out) & mask}, {24'h0, exp & mask});
	endtask : pchk

	task ichk(input logic exp);
		@(posedge hclk);
		chk({31'h0, irq}, {31'h0, exp});
	endtask : ichk

	task give_verdict;
		$display("checks %0d mismatches %0d", n_checks, err_count);
		if (err_count == 0 && n_checks > 0) begin
			$display("STATUS OK");
		end else begin
			$display("STATUS NOT OK");
		end
		$finish;
	endtask : give_verdict

	initial begin
		repeat (60000) @(posedge hclk);
		err_count++;
		give_verdict;
	end

	////////////////////////////////////////////////////////////////////////////////
	initial begin
		{hsel, hwrite, htrans, haddr, hwdata, cyc, err_count, n_checks, wdt_hits} = '0;
		port1_latch = 8'h00;
		port1_latch_oe_n = 8'hFF;
		hresetn = 1'b0;
		v = $urandom(32'hCCFD);
		repeat (12) @(posedge hclk);
		hresetn <= 1'b1;
		@(posedge hclk);
		foreach (divs[i]) rchk(32'h4 * i, 32'h0);
		wr(32'hF0, 32'hFF);
		rchk(32'hF0, 32'h0);
		for (int i = 0; i < 8; i++) begin
			wr(`CAT_OFF_MODE, i);
			rchk(`CAT_OFF_MODE, i);
		end
		v = $urandom & 16'hFFFF;
		wr(`CAT_OFF_COUNT_LO, v & 8'hFF);
		wr(`CAT_OFF_COUNT_HI, v >> 8);
		repeat (30) @(posedge hclk);
		rchk(`CAT_OFF_COUNT_LO, v & 8'hFF);
		rchk(`CAT_OFF_COUNT_HI, v >> 8);
		// two reads spaced by whole prescaler periods see an exact step count
		for (int i = 0; i < 4; i++) begin
			wr(`CAT_OFF_CONFIG, i & 1);
			wr(`CAT_OFF_MODE, (i >> 1) << 1);
			wr(`CAT_OFF_CONTROL, 8'h40);
			bus(`CAT_OFF_COUNT_LO, 1'b0, 32'h0);
			a = q;
			repeat (20 * divs[i] - lat) @(posedge hclk);
			rchk(`CAT_OFF_COUNT_LO, (a + 20) & 8'hFF);
			wr(`CAT_OFF_CONTROL, 8'h00);
		end
		wr(`CAT_OFF_CONFIG, 0);
		wr(`CAT_OFF_MODE, 8'h04);
		wr(`CAT_OFF_COUNT_LO, 0);
		wr(`CAT_OFF_CONTROL, 8'h40);
		u_far.pulse_t0(9);
		rchk(`CAT_OFF_COUNT_LO, 9);
		wr(`CAT_OFF_MODE, 8'h06);
		wr(`CAT_OFF_COUNT_LO, 0);
		u_far.ext_falls(7);
		repeat (4) @(posedge hclk);
		rchk(`CAT_OFF_COUNT_LO, 7);
		wr(`CAT_OFF_CONTROL, 0);
		wr(`CAT_OFF_MODE, 8'h05);
		wr(`CAT_OFF_IRQ_MASK, 1);
		wr(`CAT_OFF_COUNT_LO, 8'hFF);
		wr(`CAT_OFF_COUNT_HI, 8'hFF);
		wr(`CAT_OFF_CONTROL, 8'h40);
		u_far.pulse_t0(1);
		rchk(`CAT_OFF_CONTROL, 8'hC0);
		rchk(`CAT_OFF_COUNT_HI, 0);
		ichk(1'b1);
		u_far.pulse_t0(3);
		rchk(`CAT_OFF_CONTROL, 8'hC0);
		wr(`CAT_OFF_IRQ_MASK, 0);
		ichk(1'b0);
		wr(`CAT_OFF_IRQ_MASK, 1);
		wr(`CAT_OFF_CONTROL, 8'h40);
		rchk(`CAT_OFF_CONTROL, 8'h40);
		rchk(`CAT_OFF_IRQ_STATUS, 1);
		wr(`CAT_OFF_IRQ_STATUS, 1);
		ichk(1'b0);
		for (int i = 0; i < 5; i++) begin
			m = `CAT_OFF_MOD_BASE + `CAT_OFF_MOD_STRIDE * i;
			wr(`CAT_OFF_CONTROL, 0);
			v = $urandom & 16'hFFFF;
			wr(`CAT_OFF_COUNT_LO, v & 8'hFF);
			wr(`CAT_OFF_COUNT_HI, v >> 8);
			wr(m, 8'h21);
			wr(`CAT_OFF_IRQ_MASK, 2 << i);
			u_far.set_pin(i, 1'b1);
			repeat (4) @(posedge hclk);
			rchk(`CAT_OFF_CONTROL, 1 << i);
			rchk(m + `CAT_OFF_MOD_LO, v & 8'hFF);
			rchk(m + `CAT_OFF_MOD_HI, v >> 8);
			rchk(`CAT_OFF_IRQ_STATUS, 2 << i);
			ichk(1'b1);
			u_far.set_pin(i, 1'b0);
			wr(`CAT_OFF_CONTROL, 0);
			rchk(`CAT_OFF_CONTROL, 0);
			wr(`CAT_OFF_IRQ_STATUS, 8'h3F);
			wr(m, 8'h00);
		end
		for (int i = 0; i < 5; i++) begin
			m = `CAT_OFF_MOD_BASE + `CAT_OFF_MOD_STRIDE * i;
			n = 8 << i;
			port1_latch <= $urandom;
			port1_latch_oe_n <= $urandom;
			wr(m, 8'h04);
			pchk(8'h01, 8'hFF, port1_latch_oe_n & ~n);
			pchk(8'h00, ~n, port1_latch);
			wr(m, 8'h00);
			pchk(8'h01, 8'hFF, port1_latch_oe_n);
		end
		// module 4 compare: one match toggles its pin, flags it and pulses the reset
		m = `CAT_OFF_MOD_BASE + `CAT_OFF_MOD_STRIDE * 4;
		v = $urandom & 16'h7FFF;
		wr(`CAT_OFF_COUNT_LO, v & 8'hFF);
		wr(`CAT_OFF_COUNT_HI, v >> 8);
		wr(m + `CAT_OFF_MOD_LO, (v + 3) & 8'hFF);
		wr(m + `CAT_OFF_MOD_HI, (v + 3) >> 8);
		wr(m, 8'h4D);
		wr(`CAT_OFF_MODE, 8'h42);
		wr(`CAT_OFF_IRQ_MASK, 8'h20);
		wr(`CAT_OFF_CONTROL, 8'h40);
		repeat (20) @(posedge hclk);
		rchk(`CAT_OFF_CONTROL, 8'h50);
		rchk(`CAT_OFF_IRQ_STATUS, 8'h20);
		pchk(8'h00, 8'h80, 8'h80);
		chk(wdt_hits, 1);
		give_verdict;
	end
endmodule : cat_time_base_tb
